// >>> shared/timer_output_regs.vh
// Register offsets, field positions and reset values of the timer output and input block
// Notes on behaviour
// - Polarity bit one gives active-low output
// - Polarity change takes effect at next output change
// - Mode zero toggles output on own request
// - Mode one: master sets, own request clears
// - Mode acts at set/reset, only while enabled
// - Mode register takes wide or low-byte writes
// - Mode register resets to zero
// - Select bit picks interrupt pin or serial receive
// - Filter on: synchronise, accept two-cycle stable level
// - Filter off: synchronise only
// - One filter enable bit per channel
// - Select and filter registers reset to zero
// - Output enabled: software output writes ignored
`ifndef TIMER_OUTPUT_REGS_VH
`define TIMER_OUTPUT_REGS_VH

// Register addresses
`define ADDR_FILTER_EN 20'hf0071
`define ADDR_INPUT_SWITCH 20'hf0073
`define ADDR_OUT_LEVEL 20'hf01b8
`define ADDR_OUT_ENABLE 20'hf01ba
`define ADDR_OUT_POLARITY 20'hf01bc
`define ADDR_OUT_MODE 20'hf01be
`define ADDR_IRQ_STATUS 20'hf0080
`define ADDR_IRQ_CLEAR 20'hf0082
`define ADDR_IRQ_ENABLE 20'hf0084
`define ADDR_INPUT_STATE 20'hf0086

// Field positions in the input switch register
`define SEL_INT_BIT 0
`define SEL_PIN_BIT 1

// Writable channel bits of the polarity and mode registers
`define CHAN_BIT_MASK 8'hfe

// Reset values
`define RST_FILTER_EN 8'h00
`define RST_INPUT_SWITCH 8'h00
`define RST_OUT_MODE 8'h00
`define RST_OUT_POLARITY 8'h00
`define RST_OUT_ENABLE 8'h00
`define RST_OUT_LEVEL 8'h00
`define RST_IRQ 8'h00

`endif

// >>> core/input_filter.v
// Per-channel timer input synchroniser with optional stability filter
module input_filter (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pin and control
    input wire pinIn,
    input wire filterOn,
    // Conditioned level and change pulse
    output reg levelOut,
    output reg changed
);

    reg sync1;
    reg sync2;
    reg sample;
    wire levelNext;

    // Two-flop synchroniser; only sync2 reads sync1
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sample <= 1'b0;
        end else begin
            sync1 <= pinIn;
            sync2 <= sync1;
            sample <= sync2;
        end
    end

    // Filter accepts a level only when two consecutive samples agree
    assign levelNext = filterOn ? ((sync2 == sample) ? sync2 : levelOut) : sync2;

    // Registered result and one-cycle change pulse
    always @(posedge clk) begin
        if (!rst_n) begin
            levelOut <= 1'b0;
            changed <= 1'b0;
        end else begin
            levelOut <= levelNext;
            changed <= levelNext != levelOut;
        end
    end

endmodule

// >>> core/output_channel.v
// Per-channel timer output generator: toggle or set/reset with polarity
module output_channel (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Settings
    input wire modeBit,
    input wire polBit,
    input wire enableBit,
    // Timer events
    input wire ownIrq,
    input wire masterIrq,
    // Software write of the output level
    input wire swWrite,
    input wire swLevel,
    // Pin level
    output reg level
);

    // Polarity in force for the level now on the pin
    reg polApplied;
    wire rawLevel;
    wire timerEvent;
    reg rawNext;

    assign rawLevel = level ^ polApplied;
    // Events only count while timer output is enabled
    assign timerEvent = enableBit & (modeBit ? (ownIrq | masterIrq) : ownIrq);

    // Active-level result of the event; reset beats set on a tie
    always @* begin
        rawNext = rawLevel;
        if (!modeBit) begin
            rawNext = ~rawLevel;
        end else if (ownIrq) begin
            rawNext = 1'b0;
        end else begin
            rawNext = 1'b1;
        end
    end

    // New polarity is picked up only when the output changes
    always @(posedge clk) begin
        if (!rst_n) begin
            level <= 1'b0;
            polApplied <= 1'b0;
        end else if (timerEvent) begin
            level <= rawNext ^ polBit;
            polApplied <= polBit;
        end else if (swWrite && !enableBit) begin
            level <= swLevel;
            polApplied <= polBit;
        end
    end

endmodule

// >>> core/timer_output_mode_and_input_filter.v
// Timer array output mode, polarity, input filtering and interrupt input switch
//
// Our own choice: strobed register access.
`include "timer_output_regs.vh"

module timer_output_mode_and_input_filter #(
    parameter CHANNELS = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [19:0] addr,
    input wire [15:0] wrData,
    input wire wrWide,
    input wire wrStrobe,
    input wire rdStrobe,
    output reg [15:0] rdData,
    // Timer interrupt requests from the counters
    input wire [CHANNELS-1:0] channelIrq,
    // Input pins
    input wire [CHANNELS-1:0] timerInPin,
    input wire serialRxPin,
    input wire extIntPin,
    // Output pins and conditioned signals
    output wire [CHANNELS-1:0] timerOut,
    output wire [CHANNELS-1:0] filteredIn,
    output reg extIntZero,
    output reg irq
);

    // Software-visible registers
    reg [7:0] filterEn_reg;
    reg [7:0] inputSwitch_reg;
    reg [7:0] outMode_reg;
    reg [7:0] outPolarity_reg;
    reg [7:0] outEnable_reg;
    reg [7:0] irqStatus_reg;
    reg [7:0] irqEnable_reg;

    // Register next values
    reg [7:0] filterEn_next;
    reg [7:0] inputSwitch_next;
    reg [7:0] outMode_next;
    reg [7:0] outPolarity_next;
    reg [7:0] outEnable_next;
    reg [7:0] irqStatus_next;
    reg [7:0] irqEnable_next;
    reg [15:0] rdData_next;

    // Decoded strobes
    wire wrFilter;
    wire wrSwitch;
    wire wrMode;
    wire wrPolarity;
    wire wrEnable;
    wire wrLevel;
    wire wrClear;
    wire wrIrqEnable;
    wire [7:0] wrByte;

    // Per-channel signals
    wire [CHANNELS-1:0] masterIrq;
    wire [CHANNELS-1:0] inputChanged;
    wire [CHANNELS-1:0] pinSource;
    wire [CHANNELS-1:0] outLevel;

    // Interrupt input path synchronisers
    reg extSync1;
    reg extSync2;
    reg rxSync1;
    reg rxSync2;

    // Write address decode; every write uses the low data byte since upper bits are zero
    assign wrByte = wrData[7:0];
    assign wrFilter = wrStrobe && (addr == `ADDR_FILTER_EN);
    assign wrSwitch = wrStrobe && (addr == `ADDR_INPUT_SWITCH);
    assign wrMode = wrStrobe && (addr == `ADDR_OUT_MODE);
    assign wrPolarity = wrStrobe && (addr == `ADDR_OUT_POLARITY);
    assign wrEnable = wrStrobe && (addr == `ADDR_OUT_ENABLE);
    assign wrLevel = wrStrobe && (addr == `ADDR_OUT_LEVEL);
    assign wrClear = wrStrobe && (addr == `ADDR_IRQ_CLEAR);
    assign wrIrqEnable = wrStrobe && (addr == `ADDR_IRQ_ENABLE);

    // Control register next values
    always @* begin
        filterEn_next = filterEn_reg;
        inputSwitch_next = inputSwitch_reg;
        outMode_next = outMode_reg;
        outPolarity_next = outPolarity_reg;
        outEnable_next = outEnable_reg;
        irqEnable_next = irqEnable_reg;
        if (wrFilter) begin
            filterEn_next = wrByte;
        end
        if (wrSwitch) begin
            // Only the two select bits are stored; other bits read zero
            inputSwitch_next = 8'h00;
            inputSwitch_next[`SEL_INT_BIT] = wrByte[`SEL_INT_BIT];
            inputSwitch_next[`SEL_PIN_BIT] = wrByte[`SEL_PIN_BIT];
        end
        if (wrMode) begin
            // Wide and low-byte writes land the same; bit zero stays clear
            outMode_next = wrByte & `CHAN_BIT_MASK;
        end
        if (wrPolarity) begin
            outPolarity_next = wrByte & `CHAN_BIT_MASK;
        end
        if (wrEnable) begin
            outEnable_next = wrByte;
        end
        if (wrIrqEnable) begin
            irqEnable_next = wrByte;
        end
    end

    // Sticky status: a change in the same cycle as a clear survives
    always @* begin
        irqStatus_next = irqStatus_reg;
        if (wrClear) begin
            irqStatus_next = irqStatus_reg & ~wrByte;
        end
        irqStatus_next = irqStatus_next | inputChanged[7:0];
    end

    // Control registers
    always @(posedge clk) begin
        if (!rst_n) begin
            filterEn_reg <= `RST_FILTER_EN;
            inputSwitch_reg <= `RST_INPUT_SWITCH;
            outMode_reg <= `RST_OUT_MODE;
            outPolarity_reg <= `RST_OUT_POLARITY;
            outEnable_reg <= `RST_OUT_ENABLE;
            irqStatus_reg <= `RST_IRQ;
            irqEnable_reg <= `RST_IRQ;
        end else begin
            filterEn_reg <= filterEn_next;
            inputSwitch_reg <= inputSwitch_next;
            outMode_reg <= outMode_next;
            outPolarity_reg <= outPolarity_next;
            outEnable_reg <= outEnable_next;
            irqStatus_reg <= irqStatus_next;
            irqEnable_reg <= irqEnable_next;
        end
    end

    // Level interrupt, registered so the pin never glitches
    always @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_next & irqEnable_next);
        end
    end

    // Read mux; unmapped addresses and the clear register read zero
    always @* begin
        rdData_next = 16'h0000;
        case (addr)
            `ADDR_FILTER_EN: begin
                rdData_next = {8'h00, filterEn_reg};
            end
            `ADDR_INPUT_SWITCH: begin
                rdData_next = {8'h00, inputSwitch_reg};
            end
            `ADDR_OUT_MODE: begin
                rdData_next = {8'h00, outMode_reg};
            end
            `ADDR_OUT_POLARITY: begin
                rdData_next = {8'h00, outPolarity_reg};
            end
            `ADDR_OUT_ENABLE: begin
                rdData_next = {8'h00, outEnable_reg};
            end
            `ADDR_OUT_LEVEL: begin
                rdData_next = {8'h00, outLevel[7:0]};
            end
            `ADDR_IRQ_STATUS: begin
                rdData_next = {8'h00, irqStatus_reg};
            end
            `ADDR_IRQ_ENABLE: begin
                rdData_next = {8'h00, irqEnable_reg};
            end
            `ADDR_INPUT_STATE: begin
                rdData_next = {8'h00, filteredIn[7:0]};
            end
            default: begin
                rdData_next = 16'h0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            rdData <= 16'h0000;
        end else if (rdStrobe) begin
            rdData <= rdData_next;
        end else begin
            rdData <= 16'h0000;
        end
    end

    // Channel seven input comes from the timer pin or the serial receive pin
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gen_source
            if (i == 7) begin : gen_sel
                assign pinSource[i] = inputSwitch_reg[`SEL_PIN_BIT] ? serialRxPin
                                                                   : timerInPin[i];
            end else begin : gen_direct
                assign pinSource[i] = timerInPin[i];
            end
        end
    endgenerate

    // Input conditioning per channel
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gen_filter
            input_filter u_filter (
                .clk(clk),
                .rst_n(rst_n),
                .pinIn(pinSource[i]),
                .filterOn(filterEn_reg[i]),
                .levelOut(filteredIn[i]),
                .changed(inputChanged[i])
            );
        end
    endgenerate

    // A slave follows the nearest lower channel whose mode bit is clear.
    // Software keeps masters at mode zero, so the walk stops at the master.
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gen_master
            if (i == 0) begin : gen_top
                assign masterIrq[i] = 1'b0;
            end else begin : gen_walk
                // Settings and requests go in as arguments so the assign sees every change
                assign masterIrq[i] = nearest(i, outMode_reg, channelIrq);
            end
        end
    endgenerate

    // Nearest master request scanning downward from a channel
    function nearest;
        input integer ch;
        input [CHANNELS-1:0] modes;
        input [CHANNELS-1:0] reqs;
        integer k;
        reg found;
        reg value;
        begin
            found = 1'b0;
            value = 1'b0;
            for (k = CHANNELS - 1; k >= 0; k = k - 1) begin
                if (k < ch && !found && !modes[k]) begin
                    found = 1'b1;
                    value = reqs[k];
                end
            end
            nearest = value;
        end
    endfunction

    // Output generation per channel
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gen_out
            output_channel u_out (
                .clk(clk),
                .rst_n(rst_n),
                .modeBit(outMode_reg[i]),
                .polBit(outPolarity_reg[i]),
                .enableBit(outEnable_reg[i]),
                .ownIrq(channelIrq[i]),
                .masterIrq(masterIrq[i]),
                .swWrite(wrLevel),
                .swLevel(wrByte[i]),
                .level(outLevel[i])
            );
        end
    endgenerate

    assign timerOut = outLevel;

    // Interrupt source pins cross into the clock domain before use
    always @(posedge clk) begin
        if (!rst_n) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            rxSync1 <= 1'b0;
            rxSync2 <= 1'b0;
        end else begin
            extSync1 <= extIntPin;
            extSync2 <= extSync1;
            rxSync1 <= serialRxPin;
            rxSync2 <= rxSync1;
        end
    end

    // External interrupt zero source: dedicated pin or receive line for wakeup
    always @(posedge clk) begin
        if (!rst_n) begin
            extIntZero <= 1'b0;
        end else if (inputSwitch_reg[`SEL_INT_BIT]) begin
            extIntZero <= rxSync2;
        end else begin
            extIntZero <= extSync2;
        end
    end

endmodule

// >>> bench/output_filter_asserts.sv
// Port-level assertions for the timer output mode and input conditioning block
module output_filter_asserts #(
    parameter CHANNELS = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [19:0] addr,
    input wire [15:0] wrData,
    input wire wrStrobe,
    // Events and pins
    input wire [CHANNELS-1:0] channelIrq,
    input wire [CHANNELS-1:0] timerInPin,
    input wire serialRxPin,
    input wire extIntPin,
    input wire [CHANNELS-1:0] timerOut,
    input wire [CHANNELS-1:0] filteredIn,
    input wire extIntZero
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] filt, oe, pol, mode;
    logic [1:0] sel;
    logic [2:0] quiet;
    wire outWr = wrStrobe && addr == 20'hf01b8;
    wire polWr = wrStrobe && addr == 20'hf01bc;
    wire [7:0] src = {sel[1] ? serialRxPin : timerInPin[7], timerInPin[6:0]};
    genvar i;
    // Input pipelines are only judged once their settings have been still for four cycles
    always @(posedge clk) begin
        if (!rst_n || (wrStrobe && (addr == 20'hf0071 || addr == 20'hf0073))) begin
            quiet <= 3'd0;
        end else if (quiet != 3'd4) begin
            quiet <= quiet + 3'd1;
        end
    end
    // Shadow settings, so that no view of the bodies is needed
    always @(posedge clk) begin
        if (!rst_n) begin
            filt <= 8'h00;
            sel <= 2'h0;
            oe <= 8'h00;
            pol <= 8'h00;
            mode <= 8'h00;
        end else if (wrStrobe) begin
            case (addr)
                20'hf0071: filt <= wrData[7:0];
                20'hf0073: sel <= wrData[1:0];
                20'hf01ba: oe <= wrData[7:0];
                20'hf01bc: pol <= wrData[7:0] & 8'hfe;
                20'hf01be: mode <= wrData[7:0] & 8'hfe;
                default: ;
            endcase
        end
    end
    toggle_own_a: assert property (
        oe[0] && channelIrq[0] |=> timerOut[0] != $past(timerOut[0]))
        else $error("no toggle on own request");
    frozen_off_a: assert property (
        !oe[0] && !outWr |=> $stable(timerOut[0]))
        else $error("disabled output moved");
    sw_ignored_a: assert property (
        oe[0] && outWr && !channelIrq[0] |=> $stable(timerOut[0]))
        else $error("software write reached enabled output");
    sw_level_a: assert property (
        !oe[0] && outWr |=> timerOut[0] == $past(wrData[0]))
        else $error("software level not on pin");
    slave_set_a: assert property (
        oe[1] && mode[1] && channelIrq[0] && !channelIrq[1] |=> timerOut[1] == !$past(pol[1]))
        else $error("slave not set by master");
    slave_clear_a: assert property (
        oe[1] && mode[1] && channelIrq[1] |=> timerOut[1] == $past(pol[1]))
        else $error("slave not reset by own request");
    pol_defer_a: assert property (
        oe[1] && polWr && channelIrq[1:0] == 2'b00 |=> $stable(timerOut[1]))
        else $error("polarity applied at write");
    int_source_a: assert property (
        quiet == 3'd4 |-> extIntZero == (sel[0] ? $past(serialRxPin, 3) : $past(extIntPin, 3)))
        else $error("wrong interrupt source");
    for (i = 0; i < 8; i = i + 1) begin : g_ch
        sync_only_a: assert property (
            quiet == 3'd4 && !filt[i] |-> filteredIn[i] == $past(src[i], 3))
            else $error("unfiltered input wrong");
        two_agree_a: assert property (
            quiet == 3'd4 && filt[i] |-> filteredIn[i] ==
            (($past(src[i], 3) == $past(src[i], 4)) ? $past(src[i], 3) : $past(filteredIn[i])))
            else $error("filtered input wrong");
    end
endmodule

// >>> bench/pin_model.sv
// Pins outside the block: timer inputs, serial receive and interrupt pin
module pin_model (
    // Clock the pins are timed against
    input wire clk,
    // Levels and one-cycle inversions asked for by the bench
    input wire [7:0] tiLevel,
    input wire [7:0] tiGlitch,
    input wire rxLevel,
    input wire intLevel,
    // Pin levels seen by the block
    output logic [7:0] timerInPin,
    output logic serialRxPin,
    output logic extIntPin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins start low so the block never samples an unknown
    initial begin
        timerInPin = 8'h00;
        serialRxPin = 1'b0;
        extIntPin = 1'b0;
    end
    // Pins are asynchronous: they move 3 ns after an edge, so a glitch spans one sample
    always @(posedge clk) begin
        timerInPin <= #3 tiLevel ^ tiGlitch;
        serialRxPin <= #3 rxLevel;
        extIntPin <= #3 intLevel;
    end
endmodule

// >>> bench/timer_output_mode_and_input_filter_bench.sv
// Self-checking bench for the timer output mode and input filter block
module timer_output_mode_and_input_filter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wrData = 16'h0000;
    logic wrWide = 1'b0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [7:0] channelIrq = 8'h00;
    logic [7:0] tiLevel = 8'h00;
    logic [7:0] tiGlitch = 8'h00;
    logic rxLevel = 1'b0;
    logic intLevel = 1'b0;
    wire [15:0] rdData;
    wire [7:0] timerInPin, timerOut, filteredIn;
    wire serialRxPin, extIntPin, extIntZero, irq;
    logic [36:0] expQ[$];
    logic [36:0] ent;
    logic rdV = 1'b0;
    logic irqExp = 1'b0;
    logic [7:0] lvl;
    logic [19:0] regs[10] = '{20'hf0071, 20'hf0073, 20'hf01be, 20'hf01bc, 20'hf01ba,
        20'hf01b8, 20'hf0080, 20'hf0084, 20'hf0086, 20'hf0000};
    int num_errors = 0;
    int cmp_count = 0;
    int testNo = 0;
    always #5 clk = ~clk;
    timer_output_mode_and_input_filter #(.CHANNELS(8)) timer_output_mode_and_input_filter_inst (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrWide(wrWide),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .channelIrq(channelIrq),
        .timerInPin(timerInPin), .serialRxPin(serialRxPin), .extIntPin(extIntPin),
        .timerOut(timerOut), .filteredIn(filteredIn), .extIntZero(extIntZero), .irq(irq));
    pin_model pin_model_inst (
        .clk(clk), .tiLevel(tiLevel), .tiGlitch(tiGlitch), .rxLevel(rxLevel),
        .intLevel(intLevel), .timerInPin(timerInPin), .serialRxPin(serialRxPin),
        .extIntPin(extIntPin));
    // Register write: one strobe cycle beside address and data
    task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrWide <= w;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    // Register read: expected data and interrupt level go to the queue
    task automatic rd(input logic [19:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        expQ.push_back({a, e, irqExp});
        @(posedge clk);
        rdStrobe <= 1'b0;
    endtask
    // One-cycle counter requests and pin glitches
    task automatic ev(input logic [7:0] q, input logic [7:0] g);
        @(posedge clk);
        channelIrq <= q;
        tiGlitch <= g;
        @(posedge clk);
        channelIrq <= 8'h00;
        tiGlitch <= 8'h00;
    endtask
    // Direct pin check, taken mid-cycle where the output has settled
    task automatic chk(input string nm, input logic e, input logic g);
        @(negedge clk);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic done();
        testNo++;
        $display("test %0d done", testNo);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so compare mid-way through it
    always @(posedge clk) rdV <= rdStrobe;
    always @(negedge clk) begin
        if (rdV) begin
            ent = expQ.pop_front();
            cmp_count++;
            if (rdData !== ent[16:1] || irq !== ent[0]) begin
                num_errors++;
                $display("[FAIL] reg %h exp %h irq %b got %h irq %b", ent[36:17], ent[16:1],
                    ent[0], rdData, irq);
            end
        end
    end
    initial begin
        void'($urandom(32'h1be7));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[k]) begin
            rd(regs[k], 16'h0000);
        end
        done();
        // Wide and low-byte writes, random polarity with reserved bits kept clear
        wr(20'hf01be, 16'h00aa);
        rd(20'hf01be, 16'h00aa);
        wr(20'hf01be, 16'h0054, 1'b0);
        rd(20'hf01be, 16'h0054);
        lvl = 8'($urandom) & 8'hfe;
        wr(20'hf01bc, {8'h00, lvl});
        rd(20'hf01bc, {8'h00, lvl});
        wr(20'hf01bc, 16'h0000);
        wr(20'hf01be, 16'h0000);
        done();
        // Toggle mode, disabled then enabled
        ev(8'h01, 8'h00);
        rd(20'hf01b8, 16'h0000);
        wr(20'hf01ba, 16'h0003);
        ev(8'h01, 8'h00);
        rd(20'hf01b8, 16'h0001);
        chk("timerOut0", 1'b1, timerOut[0]);
        ev(8'h01, 8'h00);
        rd(20'hf01b8, 16'h0000);
        wr(20'hf01b8, 16'h0003);
        rd(20'hf01b8, 16'h0000);
        wr(20'hf01ba, 16'h0000);
        wr(20'hf01b8, 16'h0002, 1'b0);
        rd(20'hf01b8, 16'h0002);
        done();
        // Slave set/reset with active-low output, then a deferred polarity change
        wr(20'hf01be, 16'h0002);
        wr(20'hf01bc, 16'h0002);
        wr(20'hf01ba, 16'h0003);
        ev(8'h01, 8'h00);
        rd(20'hf01b8, 16'h0001);
        ev(8'h02, 8'h00);
        rd(20'hf01b8, 16'h0003);
        chk("timerOut1", 1'b1, timerOut[1]);
        wr(20'hf01bc, 16'h0000);
        rd(20'hf01b8, 16'h0003);
        ev(8'h01, 8'h00);
        rd(20'hf01b8, 16'h0002);
        ev(8'h03, 8'h00);
        rd(20'hf01b8, 16'h0001);
        wr(20'hf01ba, 16'h0000);
        wr(20'hf01be, 16'h0000);
        done();
        // Filters on channels 4 to 7; a one-sample glitch passes only the unfiltered ones
        wr(20'hf0071, 16'h00f0);
        lvl = 8'($urandom);
        tiLevel <= lvl;
        intLevel <= 1'b1;
        repeat (8) @(posedge clk);
        rd(20'hf0086, {8'h00, lvl});
        chk("filteredIn0", lvl[0], filteredIn[0]);
        wr(20'hf0082, 16'h00ff);
        rd(20'hf0080, 16'h0000);
        ev(8'h00, 8'hff);
        repeat (8) @(posedge clk);
        rd(20'hf0080, 16'h000f);
        wr(20'hf0084, 16'h0001);
        irqExp = 1'b1;
        rd(20'hf0080, 16'h000f);
        wr(20'hf0082, 16'h0001);
        irqExp = 1'b0;
        rd(20'hf0080, 16'h000e);
        wr(20'hf0084, 16'h0000);
        done();
        // Channel 7 steered to serial receive, then interrupt source switched
        wr(20'hf0073, 16'h0002);
        rxLevel <= ~lvl[7];
        repeat (8) @(posedge clk);
        rd(20'hf0086, {8'h00, ~lvl[7], lvl[6:0]});
        chk("extIntZero pin", intLevel, extIntZero);
        wr(20'hf0073, 16'h0001);
        repeat (8) @(posedge clk);
        rxLevel <= ~rxLevel;
        repeat (8) @(posedge clk);
        rd(20'hf0073, 16'h0001);
        chk("extIntZero rx", rxLevel, extIntZero);
        done();
        wrap_up();
    end
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule

bind timer_output_mode_and_input_filter output_filter_asserts #(.CHANNELS(CHANNELS))
    output_filter_asserts_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .channelIrq(channelIrq), .timerInPin(timerInPin), .serialRxPin(serialRxPin),
    .extIntPin(extIntPin), .timerOut(timerOut), .filteredIn(filteredIn),
    .extIntZero(extIntZero));
